// ===== common/uod_pkg.sv
// Constants, types and helpers shared by the opcode dispatch block
package uod_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int UOD_AW = 14;
    localparam int UOD_DW = 16;
    localparam int UOD_RAW = 6;
    localparam int UOD_NENT = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode field positions
    localparam int UOD_PFX_BIT = 11;
    localparam int UOD_BLK_HI = 8;
    localparam int UOD_BLK_LO = 4;
    localparam int UOD_SUB_HI = 3;
    localparam logic [3:0] UOD_TOP_NIB = 4'h8;
    localparam logic [1:0] UOD_PFX_LOW = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Control store addresses
    localparam logic [13:0] UOD_JTAB_LOC = 14'h0192;
    localparam logic [13:0] UOD_INT_VEC = 14'h0100;
    localparam logic [13:0] UOD_FOREIGN_ENTRY = 14'h0080;
    localparam logic [13:0] UOD_UNMAPPED_BASE = 14'h0000;
    localparam logic [13:0] UOD_GRP4_BASE = 14'h0800;
    localparam logic [13:0] UOD_GRP5_BASE = 14'h3000;
    localparam logic [13:0] UOD_GRP6_BASE = 14'h2000;
    localparam logic [2:0] UOD_GRP4 = 3'h4;
    localparam logic [2:0] UOD_GRP5 = 3'h5;
    localparam logic [2:0] UOD_GRP6 = 3'h6;
    localparam int UOD_BLK_SHIFT = 9;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets and reset values
    localparam logic [5:0] UOD_REG_CTRL = 6'h00;
    localparam logic [5:0] UOD_REG_INSTR = 6'h01;
    localparam logic [5:0] UOD_REG_STATUS = 6'h02;
    localparam logic [5:0] UOD_REG_LAST = 6'h03;
    localparam logic [5:0] UOD_REG_COUNT = 6'h04;
    localparam logic [5:0] UOD_REG_TBL = 6'h20;
    localparam logic UOD_CTRL_RST = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Dispatch states
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_JTAB   = 4'h2,
        ST_BRANCH = 4'h4,
        ST_INTR   = 4'h8
    } uod_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [13:0] uod_subst(input logic [13:0] target,
                                              input logic [15:0] instr);
        uod_subst = {target[13:4], instr[UOD_SUB_HI:0]};
    endfunction

    function automatic logic uod_is_user(input logic [15:0] instr);
        uod_is_user = (instr[15:12] == UOD_TOP_NIB) && (instr[10:9] == UOD_PFX_LOW);
    endfunction

    function automatic logic [4:0] uod_blk_idx(input logic [15:0] instr);
        uod_blk_idx = instr[UOD_BLK_HI:UOD_BLK_LO];
    endfunction

    function automatic logic [13:0] uod_default_base(input logic [4:0] idx);
        logic [13:0] off;
        off = 14'({idx[1:0]} << UOD_BLK_SHIFT);
        case (idx[4:2])
            UOD_GRP4: uod_default_base = UOD_GRP4_BASE | off;
            UOD_GRP5: uod_default_base = UOD_GRP5_BASE | off;
            UOD_GRP6: uod_default_base = UOD_GRP6_BASE | off;
            default:  uod_default_base = UOD_UNMAPPED_BASE;
        endcase
    endfunction

endpackage

// ===== common/uod_tbl_if.sv
// Link between the dispatcher and its jump table
`timescale 1ns/1ns
interface uod_tbl_if;
    logic        wr_en;
    logic [4:0]  wr_idx;
    logic [13:0] wr_data;
    logic [4:0]  rd_idx;
    logic [13:0] rd_base;
    logic [4:0]  bus_idx;
    logic [13:0] bus_base;

    modport table_side (
        input  wr_en, wr_idx, wr_data, rd_idx, bus_idx,
        output rd_base, bus_base
    );
    modport user_side (
        output wr_en, wr_idx, wr_data, rd_idx, bus_idx,
        input  rd_base, bus_base
    );
endinterface

// ===== design/uod_jump_table.sv
// Dispatch jump table: block bases indexed by opcode bits 8..4
`timescale 1ns/1ns
module uod_jump_table
    import uod_pkg::*;
(
    // Clock and reset
    input  wire logic   MCLK_I,
    input  wire logic   RST_B_I,
    // Table access
    uod_tbl_if.table_side tbl
);

    typedef struct packed {
        logic [UOD_NENT-1:0][13:0] ent;
    } uod_tbl_st_t;

    uod_tbl_st_t r;
    uod_tbl_st_t next_r;

    always_comb begin
        next_r = r;
        if (tbl.wr_en) begin
            next_r.ent[tbl.wr_idx] = tbl.wr_data;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < UOD_NENT; i++) begin
                r.ent[i] <= uod_default_base(5'(i));
            end
        end else begin
            r <= next_r;
        end
    end

    // Indexed lookup, never a direct address
    assign tbl.rd_base = r.ent[tbl.rd_idx];
    assign tbl.bus_base = r.ent[tbl.bus_idx];

endmodule

// ===== design/uod_user_opcode_dispatch.sv
// User opcode dispatcher: current instruction to control store entry
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Opcodes with top bits 105 or 101 octal are user group; bit 11 marks 105.
// - Decode is per block of sixteen codes; microcode finishes the selection.
// - Block is chosen by instruction bits 8 down to 4.
// - Bits 3..0 pick one of the first sixteen locations of the block.
// - Accumulator select follows bit 11: zero first, one second accumulator.
// - Bits 8..4 index a jump table whose entry branches to block base.
// - Table branch replaces low four target bits with instruction low nibble.
// - Base 0x3000 table branch reaches 0x3000 to 0x300F.
// - Blocks 500..577 map to bases 3000, 3200, 3400, 3600 hex.
// - Blocks 600..677 map to bases 2000, 2200, 2400, 2600 hex.
// - Blocks 400..477 map to reserved bases 0800, 0A00, 0C00, 0E00 hex.
// - Memory mapping group decodes through two table branches outside the table.
// - Outside table branches also insert instruction bits 3..0 into address.
// - Dispatch cycle clears flag, increments program counter, forces decode orders.
// - Loop loads accumulator with ones, then dispatches through the table unless an interrupt is pending.
// - Pending interrupt branches to handler and loads priority code into instruction.
module uod_user_opcode_dispatch
    import uod_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RST_B_I,
    // Register port
    input  wire logic [5:0]  REG_ADDR_I,
    input  wire logic [15:0] REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [15:0] REG_RDATA_O,
    // Fetch path
    input  wire logic        INSTR_LOAD_I,
    input  wire logic [15:0] INSTR_DATA_I,
    // Microsequencer commands
    input  wire logic        LOOP_I,
    input  wire logic        TBL_BRANCH_I,
    input  wire logic [13:0] TBL_TARGET_I,
    input  wire logic        INT_PENDING_I,
    input  wire logic [15:0] INT_CODE_I,
    // Microsequencer results
    output logic      [13:0] UADDR_O,
    output logic             UADDR_VALID_O,
    output logic             CLR_FLAG_O,
    output logic             PC_INC_O,
    output logic             FORCE_MRG_O,
    output logic             ACC_ONES_O,
    output logic             ACC_SEL_O,
    output logic      [15:0] INSTR_O,
    output logic             USER_GROUP_O,
    output logic             BUSY_O
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        uod_state_t  state;
        logic [15:0] current_instruction_reg;
        logic        user_opcode_group;
        logic [13:0] uaddr;
        logic        uaddr_valid;
        logic        clr_flag;
        logic        program_counter_increment;
        logic        force_mrg;
        logic        acc_ones;
        logic [13:0] entry_base;
        logic [13:0] last_entry;
        logic        disp_en;
        logic        intr_seen;
        logic [15:0] disp_count;
        logic [15:0] rd_data;
    } uod_main_st_t;

    uod_main_st_t r;
    uod_main_st_t next_r;

    uod_tbl_if tbl ();

    ////////////////////////////////////////////////////////////////////////////
    // Jump table

    uod_jump_table u_table (
        .MCLK_I  (MCLK_I),
        .RST_B_I (RST_B_I),
        .tbl     (tbl)
    );

    logic        tbl_wr;
    logic        status_clr;
    logic [15:0] rd_mux;

    // Table writes share the register port
    assign tbl_wr = REG_WR_I && (REG_ADDR_I[5] == UOD_REG_TBL[5]);
    assign tbl.wr_en = tbl_wr;
    assign tbl.wr_idx = REG_ADDR_I[4:0];
    assign tbl.wr_data = REG_WDATA_I[13:0];
    assign tbl.bus_idx = REG_ADDR_I[4:0];
    // Bit 11 is not part of the index, so both prefixes share an entry
    assign tbl.rd_idx = uod_blk_idx(r.current_instruction_reg);

    assign status_clr = REG_WR_I && (REG_ADDR_I == UOD_REG_STATUS) && REG_WDATA_I[0];

    ////////////////////////////////////////////////////////////////////////////
    // Register read mux

    always_comb begin
        rd_mux = 16'h0000;
        if (REG_ADDR_I[5] == UOD_REG_TBL[5]) begin
            rd_mux = {2'h0, tbl.bus_base};
        end else begin
            case (REG_ADDR_I)
                UOD_REG_CTRL:   rd_mux = {15'h0000, r.disp_en};
                UOD_REG_INSTR:  rd_mux = r.current_instruction_reg;
                UOD_REG_STATUS: rd_mux = {11'h000, r.state, r.intr_seen};
                UOD_REG_LAST:   rd_mux = {2'h0, r.last_entry};
                UOD_REG_COUNT:  rd_mux = r.disp_count;
                default:        rd_mux = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r = r;
        next_r.uaddr_valid = 1'b0;
        next_r.clr_flag = 1'b0;
        next_r.program_counter_increment = 1'b0;
        next_r.force_mrg = 1'b0;
        next_r.acc_ones = 1'b0;
        next_r.rd_data = REG_RD_I ? rd_mux : 16'h0000;

        if (REG_WR_I && (REG_ADDR_I == UOD_REG_CTRL)) begin
            next_r.disp_en = REG_WDATA_I[0];
        end
        // Software clear loses to a fresh interrupt in the same cycle
        next_r.intr_seen = r.intr_seen & ~status_clr;

        case (r.state)
            ST_IDLE: begin
                if (INSTR_LOAD_I) begin
                    next_r.current_instruction_reg = INSTR_DATA_I;
                    next_r.user_opcode_group = uod_is_user(INSTR_DATA_I);
                end
                if (LOOP_I && r.disp_en) begin
                    next_r.acc_ones = 1'b1;
                    if (INT_PENDING_I) begin
                        next_r.state = ST_INTR;
                    end else begin
                        next_r.state = ST_JTAB;
                    end
                end else if (TBL_BRANCH_I) begin
                    // Second-level decode outside the jump table
                    next_r.uaddr = uod_subst(TBL_TARGET_I, r.current_instruction_reg);
                    next_r.uaddr_valid = 1'b1;
                end
            end
            ST_JTAB: begin
                next_r.clr_flag = 1'b1;
                next_r.program_counter_increment = 1'b1;
                next_r.force_mrg = 1'b1;
                next_r.uaddr = UOD_JTAB_LOC + {9'h000, tbl.rd_idx};
                next_r.uaddr_valid = 1'b1;
                if (r.user_opcode_group) begin
                    next_r.entry_base = tbl.rd_base;
                end else begin
                    next_r.entry_base = UOD_FOREIGN_ENTRY;
                end
                next_r.state = ST_BRANCH;
            end
            ST_BRANCH: begin
                // Low nibble picks one of sixteen entries in the block
                next_r.uaddr = uod_subst(r.entry_base, r.current_instruction_reg);
                next_r.uaddr_valid = 1'b1;
                next_r.last_entry = uod_subst(r.entry_base, r.current_instruction_reg);
                next_r.disp_count = r.disp_count + 16'h0001;
                next_r.state = ST_IDLE;
            end
            ST_INTR: begin
                next_r.uaddr = UOD_INT_VEC;
                next_r.uaddr_valid = 1'b1;
                next_r.current_instruction_reg = INT_CODE_I;
                next_r.user_opcode_group = uod_is_user(INT_CODE_I);
                next_r.intr_seen = 1'b1;
                next_r.state = ST_IDLE;
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            r.state <= ST_IDLE;
            r.current_instruction_reg <= 16'h0000;
            r.user_opcode_group <= 1'b0;
            r.uaddr <= 14'h0000;
            r.uaddr_valid <= 1'b0;
            r.clr_flag <= 1'b0;
            r.program_counter_increment <= 1'b0;
            r.force_mrg <= 1'b0;
            r.acc_ones <= 1'b0;
            r.entry_base <= 14'h0000;
            r.last_entry <= 14'h0000;
            r.disp_en <= UOD_CTRL_RST;
            r.intr_seen <= 1'b0;
            r.disp_count <= 16'h0000;
            r.rd_data <= 16'h0000;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign REG_RDATA_O = r.rd_data;
    assign UADDR_O = r.uaddr;
    assign UADDR_VALID_O = r.uaddr_valid;
    assign CLR_FLAG_O = r.clr_flag;
    assign PC_INC_O = r.program_counter_increment;
    assign FORCE_MRG_O = r.force_mrg;
    assign ACC_ONES_O = r.acc_ones;
    // Accumulator select order: 0 first, 1 second accumulator
    assign ACC_SEL_O = r.current_instruction_reg[UOD_PFX_BIT];
    assign INSTR_O = r.current_instruction_reg;
    assign USER_GROUP_O = r.user_opcode_group;
    assign BUSY_O = (r.state != ST_IDLE);

endmodule

// ===== tb/uod_user_opcode_dispatch_properties.sv
// Port-level checks for the opcode dispatcher
`timescale 1ns/1ns
module uod_chk
    import uod_pkg::*;
(
    // Clock and reset
    input wire logic        MCLK_I,
    input wire logic        RST_B_I,
    // Fetch path
    input wire logic        INSTR_LOAD_I,
    input wire logic [15:0] INSTR_DATA_I,
    // Commands
    input wire logic        LOOP_I,
    input wire logic        TBL_BRANCH_I,
    input wire logic [13:0] TBL_TARGET_I,
    input wire logic        INT_PENDING_I,
    input wire logic [15:0] INT_CODE_I,
    // Results
    input wire logic [13:0] UADDR_O,
    input wire logic        UADDR_VALID_O,
    input wire logic        CLR_FLAG_O,
    input wire logic        PC_INC_O,
    input wire logic        FORCE_MRG_O,
    input wire logic        ACC_ONES_O,
    input wire logic        ACC_SEL_O,
    input wire logic [15:0] INSTR_O,
    input wire logic        USER_GROUP_O,
    input wire logic        BUSY_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    ////////////////////////////////////////////////////////////////////////////
    sequence jtab_step;
        CLR_FLAG_O && PC_INC_O && FORCE_MRG_O && UADDR_VALID_O;
    endsequence
    sequence entry_step;
        UADDR_VALID_O && UADDR_O[3:0] == $past(INSTR_O[3:0]);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    loop_ones_a: assert property (ACC_ONES_O |-> $past(LOOP_I) && !$past(BUSY_O))
        else $error("accumulator fill without a taken loop");
    ones_jtab_a: assert property (ACC_ONES_O && !$past(INT_PENDING_I) |=> jtab_step)
        else $error("dispatch cycle pulses missing");
    jtab_addr_a: assert property (CLR_FLAG_O
        |-> UADDR_O == UOD_JTAB_LOC + 14'(INSTR_O[8:4]))
        else $error("jump table address wrong");
    entry_nib_a: assert property (jtab_step |=> entry_step)
        else $error("entry low nibble not from instruction");
    grp6_base_a: assert property (CLR_FLAG_O && USER_GROUP_O && INSTR_O[8:6] == 3'h6
        |=> UADDR_O[13:4] == {3'h4, $past(INSTR_O[5:4]), 5'h00})
        else $error("group 6 base wrong");
    grp4_base_a: assert property (CLR_FLAG_O && USER_GROUP_O && INSTR_O[8:6] == 3'h4
        |=> UADDR_O[13:4] == {3'h1, $past(INSTR_O[5:4]), 5'h00})
        else $error("group 4 base wrong");
    int_entry_a: assert property (ACC_ONES_O && $past(INT_PENDING_I) |=> UADDR_VALID_O
        && UADDR_O == UOD_INT_VEC && INSTR_O == $past(INT_CODE_I))
        else $error("interrupt entry wrong");
    tbl_branch_a: assert property (TBL_BRANCH_I && !LOOP_I && !BUSY_O |=> UADDR_VALID_O
        && UADDR_O == {$past(TBL_TARGET_I[13:4]), $past(INSTR_O[3:0])})
        else $error("table branch wrong");
    acc_select_a: assert property (INSTR_LOAD_I && !BUSY_O
        |=> ACC_SEL_O == $past(INSTR_DATA_I[UOD_PFX_BIT]))
        else $error("accumulator select not bit 11");
endmodule

bind uod_user_opcode_dispatch uod_chk u_chk (
    .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .INSTR_LOAD_I(INSTR_LOAD_I),
    .INSTR_DATA_I(INSTR_DATA_I), .LOOP_I(LOOP_I), .TBL_BRANCH_I(TBL_BRANCH_I),
    .TBL_TARGET_I(TBL_TARGET_I), .INT_PENDING_I(INT_PENDING_I), .INT_CODE_I(INT_CODE_I),
    .UADDR_O(UADDR_O), .UADDR_VALID_O(UADDR_VALID_O), .CLR_FLAG_O(CLR_FLAG_O),
    .PC_INC_O(PC_INC_O), .FORCE_MRG_O(FORCE_MRG_O), .ACC_ONES_O(ACC_ONES_O),
    .ACC_SEL_O(ACC_SEL_O), .INSTR_O(INSTR_O), .USER_GROUP_O(USER_GROUP_O), .BUSY_O(BUSY_O)
);

// ===== tb/uod_useq_model.sv
// Microsequencer stand-in driving dispatch and table-branch commands
`timescale 1ns/1ns
module uod_useq_model (
    // Clock
    input  wire logic        clk_i,
    // Commands to the dispatcher
    output logic             loop_o,
    output logic             tbl_branch_o,
    output logic      [13:0] tbl_target_o,
    output logic             int_pending_o,
    output logic      [15:0] int_code_o
);
    logic [1:0] hold = 2'h0;

    initial begin
        {loop_o, tbl_branch_o, int_pending_o} = 3'h0;
        tbl_target_o = 14'h0000;
        int_code_o = 16'h0000;
    end

    // Code kept until sampled, then scrambled so stale values cannot pass
    always @(posedge clk_i) begin
        hold <= {hold[0], loop_o};
        if (hold[1]) begin
            int_code_o <= ~int_code_o;
        end
    end

    task automatic dispatch(input logic irq, input logic [15:0] code);
        loop_o <= 1'b1;
        int_pending_o <= irq;
        int_code_o <= code;
        @(posedge clk_i);
        loop_o <= 1'b0;
        int_pending_o <= 1'b0;
    endtask

    task automatic branch(input logic [13:0] target);
        tbl_branch_o <= 1'b1;
        tbl_target_o <= target;
        @(posedge clk_i);
        tbl_branch_o <= 1'b0;
        tbl_target_o <= ~target;
    endtask
endmodule

// ===== tb/uod_user_opcode_dispatch_tb_top.sv
// Self-checking bench for the user opcode dispatcher
`timescale 1ns/1ns
module uod_user_opcode_dispatch_tb_top
    import uod_pkg::*;
;
    typedef struct packed {
        logic [15:0] instr;
        logic [13:0] entry;
    } uod_row_t;

    logic        clk, rst_b, reg_wr, reg_rd, instr_load, loop, tbr, ipend;
    logic        uv, clrf, pci, fmrg, ones, asel, ugrp, busy;
    logic [5:0]  reg_addr;
    logic [13:0] uaddr, tgt;
    logic [15:0] reg_wdata, rdata, instr_data, icode, instr_o, v;
    int          n_fail, total_checks, cyc;
    uod_row_t    rows [14] = '{
        '{16'h8300, 14'h0800}, '{16'h8315, 14'h0a05}, '{16'h8b27, 14'h0c07},
        '{16'h8333, 14'h0e03}, '{16'h8b40, 14'h3000}, '{16'h8b42, 14'h3002},
        '{16'h835f, 14'h320f}, '{16'h8b65, 14'h3405}, '{16'h837f, 14'h360f},
        '{16'h8b82, 14'h2002}, '{16'h8399, 14'h2209}, '{16'h8bac, 14'h240c},
        '{16'h83bf, 14'h260f}, '{16'h1234, 14'h0084}
    };

    uod_user_opcode_dispatch u_dut (
        .MCLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .INSTR_LOAD_I(instr_load),
        .INSTR_DATA_I(instr_data), .LOOP_I(loop), .TBL_BRANCH_I(tbr), .TBL_TARGET_I(tgt),
        .INT_PENDING_I(ipend), .INT_CODE_I(icode), .UADDR_O(uaddr), .UADDR_VALID_O(uv),
        .CLR_FLAG_O(clrf), .PC_INC_O(pci), .FORCE_MRG_O(fmrg), .ACC_ONES_O(ones),
        .ACC_SEL_O(asel), .INSTR_O(instr_o), .USER_GROUP_O(ugrp), .BUSY_O(busy)
    );
    uod_useq_model u_seq (
        .clk_i(clk), .loop_o(loop), .tbl_branch_o(tbr), .tbl_target_o(tgt),
        .int_pending_o(ipend), .int_code_o(icode)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clk);
    endtask

    task automatic ld(input logic [15:0] c);
        instr_load <= 1'b1;
        instr_data <= c;
        @(posedge clk);
        instr_load <= 1'b0;
        instr_data <= ~c;
        #1;
    endtask

    // Full dispatch without interrupt, checked cycle by cycle
    task automatic disp(input logic [15:0] instr, input logic [13:0] entry);
        u_seq.dispatch(1'b0, 16'h0000);
        #1;
        chk("ones", 16'h0001, 16'(ones));
        chk("busy", 16'h0001, 16'(busy));
        @(posedge clk);
        #1;
        chk("jtab", 16'(UOD_JTAB_LOC + 14'(instr[8:4])), 16'(uaddr));
        chk("pulses", 16'h0007, 16'({clrf, pci, fmrg}));
        @(posedge clk);
        #1;
        chk("entry", 16'(entry), 16'(uaddr));
        chk("valid", 16'h0001, 16'(uv));
        chk("acc sel", 16'(instr[11]), 16'(asel));
        chk("idle", 16'h0000, 16'(busy));
        @(posedge clk);
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        {reg_wr, reg_rd, instr_load} = 3'h0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        instr_data = 16'h0000;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk("instr reset", 16'h0000, instr_o);
        rd(UOD_REG_CTRL, v);
        chk("ctrl", 16'h0001, v);
        rd(6'h34, v);
        chk("table", 16'h3000, v);
        rd(6'h10, v);
        chk("unmapped", 16'h0000, v);
        foreach (rows[i]) begin
            for (int p = 0; p < 2; p++) begin
                v = rows[i].instr ^ (p == 1 ? 16'h0800 : 16'h0000);
                ld(v);
                chk("user", 16'(v[15:12] == 4'h8 && v[10:9] == 2'h1), 16'(ugrp));
                disp(v, rows[i].entry);
            end
        end
        // Rewritten table entry moves its block
        wr(6'h35, 16'h3a00);
        ld(16'h8b57);
        disp(16'h8b57, 14'h3a07);
        // Pending interrupt takes the handler path
        u_seq.dispatch(1'b1, 16'h00c5);
        @(posedge clk);
        #1;
        chk("int addr", 16'(UOD_INT_VEC), 16'(uaddr));
        chk("int code", 16'h00c5, instr_o);
        chk("int flag", 16'h0000, 16'(clrf));
        rd(UOD_REG_INSTR, v);
        chk("instr reg", 16'h00c5, v);
        // Idle state one-hot in bits 4..1 beside the flag
        rd(UOD_REG_STATUS, v);
        chk("seen", 16'h0003, v);
        wr(UOD_REG_STATUS, 16'h0001);
        rd(UOD_REG_STATUS, v);
        chk("seen clr", 16'h0002, v);
        // Loop while busy is refused
        ld(16'h8b42);
        u_seq.dispatch(1'b0, 16'h0000);
        #1;
        u_seq.dispatch(1'b0, 16'h0000);
        #1;
        chk("busy jtab", 16'h0001, 16'(clrf));
        @(posedge clk);
        #1;
        chk("busy ones", 16'h0000, 16'(ones));
        chk("busy entry", 16'h3002, 16'(uaddr));
        @(posedge clk);
        u_seq.branch(14'h1235);
        #1;
        chk("branch 1", 16'h1232, 16'(uaddr));
        u_seq.branch(14'h2a9f);
        #1;
        chk("branch 2", 16'h2a92, 16'(uaddr));
        // Table branches leave the last entry alone
        rd(UOD_REG_LAST, v);
        chk("last entry", 16'h3002, v);
        // 28 row dispatches, the moved block and the busy test
        rd(UOD_REG_COUNT, v);
        chk("count", 16'h001e, v);
        wr(UOD_REG_CTRL, 16'h0000);
        u_seq.dispatch(1'b0, 16'h0000);
        #1;
        chk("disabled", 16'h0000, 16'(ones));
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(UOD_REG_CTRL, v);
        chk("ctrl reset", 16'h0001, v);
        chk("instr again", 16'h0000, instr_o);
        finish_test();
    end
endmodule
